// [src/pes_emergency_stop.sv]
// pulse timer with emergency output stop and register port
`timescale 1ns/10ps
module pes_emergency_stop
    import pes_pkg::*;
#(
    parameter int unsigned W    = CNT_W,
    parameter int unsigned FILT = FILT_LEN
)
(
    // clock, reset, clock enable
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // operating mode of the controller
    input  wire logic              lp_mode,
    // fault input, active low
    input  wire logic              fault_stop_pin_n,
    // pulse outputs
    output logic                   ppg1_out,
    output logic                   ppg1_oe,
    output logic                   ppg2_out,
    output logic                   ppg2_oe,
    // status
    output logic                   fault_stop_flag,
    output logic                   fault_stop_irq
);

    pes_tmr_if #(.W(W)) tl ();

    logic              low_det;
    logic              hit;
    logic              rel_ok;

    // configuration
    logic              ini1_r;
    logic              ini1_nxt;
    logic              ini2_r;
    logic              ini2_nxt;
    logic              oe1_r;
    logic              oe1_nxt;
    logic              oe2_r;
    logic              oe2_nxt;
    logic              fen_r;
    logic              fen_nxt;
    logic              start_r;
    logic              start_nxt;
    logic [1:0]        stm_r;
    logic [1:0]        stm_nxt;
    logic [W-1:0]      period_r;
    logic [W-1:0]      period_nxt;
    logic [W-1:0]      dead_r;
    logic [W-1:0]      dead_nxt;

    // timer state
    pes_tmr_st_e       st_r;
    pes_tmr_st_e       st_nxt;

    // emergency state and outputs
    logic              flag_r;
    logic              flag_nxt;
    logic              irq_r;
    logic              irq_nxt;
    logic              out1_r;
    logic              out1_nxt;
    logic              out2_r;
    logic              out2_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    pes_fault_sampler #(.LEN(FILT)) u_sampler (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .pin_n   (fault_stop_pin_n),
        .low_det (low_det)
    );

    pes_wave_gen #(.W(W)) u_wave (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .tl      (tl)
    );

    // filter counts always; pin only hits while armed
    assign hit    = fen_r && low_det;
    assign rel_ok = reg_wr && (reg_addr == OFS_CR2)
                    && reg_wdata[CR2_REL_BIT]
                    && !start_r
                    && (stm_r == STM_STOP_CLR);

    // register writes and low-power initialization
    always_comb
    begin
        ini1_nxt   = ini1_r;
        ini2_nxt   = ini2_r;
        oe1_nxt    = oe1_r;
        oe2_nxt    = oe2_r;
        fen_nxt    = fen_r;
        start_nxt  = start_r;
        stm_nxt    = stm_r;
        period_nxt = period_r;
        dead_nxt   = dead_r;
        if (lp_mode)
        begin
            // timer configuration drops back to reset values
            ini1_nxt   = RST_REG[CR1_INI1_BIT];
            ini2_nxt   = RST_REG[CR1_INI2_BIT];
            oe1_nxt    = RST_REG[CR2_OE1_BIT];
            oe2_nxt    = RST_REG[CR2_OE2_BIT];
            fen_nxt    = RST_REG[CR2_FEN_BIT];
            start_nxt  = RST_REG[CR3_START_BIT];
            stm_nxt    = RST_REG[CR3_STM_LSB +: 2];
            period_nxt = RST_PERIOD;
            dead_nxt   = RST_DEAD;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OFS_CR1:
                begin
                    ini1_nxt = reg_wdata[CR1_INI1_BIT];
                    ini2_nxt = reg_wdata[CR1_INI2_BIT];
                end
                OFS_CR2:
                begin
                    oe1_nxt = reg_wdata[CR2_OE1_BIT];
                    oe2_nxt = reg_wdata[CR2_OE2_BIT];
                    fen_nxt = reg_wdata[CR2_FEN_BIT];
                end
                OFS_CR3:
                begin
                    start_nxt = reg_wdata[CR3_START_BIT];
                    stm_nxt   = reg_wdata[CR3_STM_LSB +: 2];
                end
                OFS_PERIOD: period_nxt = reg_wdata[W-1:0];
                OFS_DEAD:   dead_nxt   = reg_wdata[W-1:0];
                default:    ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ini1_r   <= RST_REG[CR1_INI1_BIT];
            ini2_r   <= RST_REG[CR1_INI2_BIT];
            oe1_r    <= RST_REG[CR2_OE1_BIT];
            oe2_r    <= RST_REG[CR2_OE2_BIT];
            fen_r    <= RST_REG[CR2_FEN_BIT];
            start_r  <= RST_REG[CR3_START_BIT];
            stm_r    <= RST_REG[CR3_STM_LSB +: 2];
            period_r <= RST_PERIOD;
            dead_r   <= RST_DEAD;
        end
        else if (clk_en)
        begin
            ini1_r   <= ini1_nxt;
            ini2_r   <= ini2_nxt;
            oe1_r    <= oe1_nxt;
            oe2_r    <= oe2_nxt;
            fen_r    <= fen_nxt;
            start_r  <= start_nxt;
            stm_r    <= stm_nxt;
            period_r <= period_nxt;
            dead_r   <= dead_nxt;
        end
    end

    // counter control; a running counter is left alone by a fault
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE:
                if (start_r && !flag_r)
                    st_nxt = ST_RUN;
            ST_RUN:
                if (!start_r)
                    st_nxt = (stm_r == STM_STOP_END) ? ST_DRAIN
                                                     : ST_IDLE;
            ST_DRAIN:
                if (tl.period_end)
                    st_nxt = ST_IDLE;
        endcase
        if (lp_mode)
            st_nxt = ST_IDLE;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            st_r <= ST_IDLE;
        else if (clk_en)
            st_r <= st_nxt;
    end

    assign tl.run    = (st_r != ST_IDLE) && !lp_mode;
    assign tl.clear  = lp_mode
                       || ((st_r == ST_IDLE)
                           && (stm_r != STM_STOP_HOLD));
    assign tl.ini1   = ini1_r;
    assign tl.ini2   = ini2_r;
    assign tl.period = period_r;
    assign tl.dead   = dead_r;

    // emergency flag: a fresh fault beats a release in the same cycle
    always_comb
    begin
        flag_nxt = flag_r;
        if (hit)
            flag_nxt = 1'b1;
        else if (rel_ok)
            flag_nxt = 1'b0;
        // pin still low at release: state re-entered, irq again
        irq_nxt = hit && (!flag_r || rel_ok);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flag_r <= 1'b0;
            irq_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            flag_r <= flag_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // pins: forced to the idle level while the flag stands
    always_comb
    begin
        out1_nxt = ini1_r;
        out2_nxt = ini2_r;
        if (!flag_r && oe1_r)
            out1_nxt = tl.wave1;
        if (!flag_r && oe2_r)
            out2_nxt = tl.wave2;
        // path pin to pin is about six clocks, well inside the limit
        if (flag_r)
        begin
            out1_nxt = ini1_r;
            out2_nxt = ini2_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out1_r <= RST_REG[CR1_INI1_BIT];
            out2_r <= RST_REG[CR1_INI2_BIT];
        end
        else if (clk_en)
        begin
            out1_r <= out1_nxt;
            out2_r <= out2_nxt;
        end
    end

    // read data stand for one cycle only; unmapped reads give zero
    always_comb
    begin
        rdata_nxt = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_CR1:
                begin
                    rdata_nxt[CR1_INI1_BIT] = ini1_r;
                    rdata_nxt[CR1_INI2_BIT] = ini2_r;
                end
                OFS_CR2:
                begin
                    rdata_nxt[CR2_OE1_BIT] = oe1_r;
                    rdata_nxt[CR2_OE2_BIT] = oe2_r;
                    rdata_nxt[CR2_FEN_BIT] = fen_r;
                end
                OFS_CR3:
                begin
                    rdata_nxt[CR3_START_BIT]      = start_r;
                    rdata_nxt[CR3_STM_LSB +: 2]   = stm_r;
                    rdata_nxt[CR3_RUN_BIT]        = tl.run;
                    rdata_nxt[CR3_FLAG_BIT]       = flag_r;
                end
                OFS_PERIOD: rdata_nxt[W-1:0] = period_r;
                OFS_DEAD:   rdata_nxt[W-1:0] = dead_r;
                default:    rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_r <= '0;
        else if (clk_en)
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata       = rdata_r;
    assign ppg1_out        = out1_r;
    assign ppg2_out        = out2_r;
    assign ppg1_oe         = oe1_r;
    assign ppg2_oe         = oe2_r;
    assign fault_stop_flag = flag_r;
    assign fault_stop_irq  = irq_r;

endmodule // pes_emergency_stop

// [src/pes_pkg.sv]
// constants and types shared by the emergency output-stop block
// Operation
// - enable bit arms fault pin, resets to 0
// - fault pin sampled on the fast clock
// - accepted stop sets the stop flag
// - every accepted stop raises the interrupt
// - release works only with start 0, mode 00
// - release with pin still low re-enters stop
// - counter cannot start while stop is active
// - outputs forced idle within 40 clocks
// - timer runs only in normal or idle modes
// - entering low-power mode initializes the timer
// - stop forces outputs only, counter keeps running
// - initial-level bit selects each idle level
package pes_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CR1    = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_CR2    = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CR3    = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_DEAD   = 3'h4;

    // field positions
    localparam int unsigned CR1_INI1_BIT  = 0;
    localparam int unsigned CR1_INI2_BIT  = 1;
    localparam int unsigned CR2_OE1_BIT   = 0;
    localparam int unsigned CR2_OE2_BIT   = 1;
    localparam int unsigned CR2_FEN_BIT   = 2;
    localparam int unsigned CR2_REL_BIT   = 7;
    localparam int unsigned CR3_START_BIT = 0;
    localparam int unsigned CR3_STM_LSB   = 1;
    localparam int unsigned CR3_RUN_BIT   = 6;
    localparam int unsigned CR3_FLAG_BIT  = 7;

    // stop-mode codes
    localparam logic [1:0] STM_STOP_CLR  = 2'h0;
    localparam logic [1:0] STM_STOP_HOLD = 2'h1;
    localparam logic [1:0] STM_STOP_END  = 2'h2;

    // reset values
    localparam logic [DATA_W-1:0] RST_REG    = 8'h00;
    localparam logic [CNT_W-1:0]  RST_PERIOD = 8'hFF;
    localparam logic [CNT_W-1:0]  RST_DEAD   = 8'h80;

    // timing: figures in periods of the high-frequency clock
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned HF_CLOCK_HZ   = 20_000_000;
    localparam int unsigned MIN_LOW_HF    = 4;
    localparam int unsigned RESP_MAX_HF   = 40;
    localparam int unsigned MIN_LOW_CYC   =
        (MIN_LOW_HF * CLK_HZ + HF_CLOCK_HZ - 1) / HF_CLOCK_HZ;
    localparam int unsigned RESP_MAX_CYC  =
        (RESP_MAX_HF * CLK_HZ) / HF_CLOCK_HZ;
    localparam int unsigned FILT_LEN      = MIN_LOW_CYC - 1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_DRAIN = 3'b100
    } pes_tmr_st_e;

endpackage

// [src/pes_tmr_if.sv]
// link between the register/control logic and the waveform counter
`timescale 1ns/10ps
interface pes_tmr_if
    import pes_pkg::*;
#(
    parameter int unsigned W = CNT_W
);
    logic         run;
    logic         clear;
    logic         ini1;
    logic         ini2;
    logic [W-1:0] period;
    logic [W-1:0] dead;
    logic         wave1;
    logic         wave2;
    logic         period_end;

    modport ctrl (output run, clear, ini1, ini2, period, dead,
                  input  wave1, wave2, period_end);
    modport gen  (input  run, clear, ini1, ini2, period, dead,
                  output wave1, wave2, period_end);
endinterface

// [src/pes_fault_sampler.sv]
// fault pin sampler with a consecutive-low filter
`timescale 1ns/10ps
module pes_fault_sampler
    import pes_pkg::*;
#(
    parameter int unsigned LEN = FILT_LEN
)
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic clk_en,
    // pin and result
    input  wire logic pin_n,
    output logic      low_det
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic       smp_r;
    logic       smp_nxt;

    // sampled every fast clock, so a halted clock stops detection
    always_comb
    begin
        smp_nxt = pin_n;
        cnt_nxt = cnt_r;
        if (smp_r)
            cnt_nxt = 4'h0;
        else if (cnt_r != 4'(LEN))
            cnt_nxt = cnt_r + 4'h1;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            smp_r <= 1'b1;
            cnt_r <= 4'h0;
        end
        else if (clk_en)
        begin
            smp_r <= smp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // the count holds the earlier lows and smp_r the latest one, so
    // LEN+1 lows in a row are needed; anything shorter is noise
    assign low_det = (cnt_r == 4'(LEN)) && !smp_r;
endmodule // pes_fault_sampler

// [src/pes_wave_gen.sv]
// period counter and two dead-time waveforms
`timescale 1ns/10ps
module pes_wave_gen
    import pes_pkg::*;
#(
    parameter int unsigned W = CNT_W
)
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic clk_en,
    // control link
    pes_tmr_if.gen    tl
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         past_dead;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (tl.clear)
            cnt_nxt = '0;
        else if (tl.run)
            cnt_nxt = tl.period_end ? '0 : cnt_r + 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_r <= '0;
        else if (clk_en)
            cnt_r <= cnt_nxt;
    end

    assign tl.period_end = tl.run && (cnt_r == tl.period);
    assign past_dead     = (cnt_r >= tl.dead);
    // level bit 0 idles low and rises at dead time; 1 is the inverse
    assign tl.wave1      = tl.ini1 ^ past_dead;
    assign tl.wave2      = tl.ini2 ^ past_dead;
endmodule // pes_wave_gen

// [test/pes_emergency_stop_chk.sv]
// port-level assertions for the emergency output-stop block
`timescale 1ns/10ps
module pes_emergency_stop_chk
    import pes_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic              clk_en,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // mode and fault pin
    input wire logic              lp_mode,
    input wire logic              fault_stop_pin_n,
    // outputs and status
    input wire logic              ppg1_out,
    input wire logic              ppg1_oe,
    input wire logic              ppg2_out,
    input wire logic              ppg2_oe,
    input wire logic              fault_stop_flag,
    input wire logic              fault_stop_irq
);
    logic [1:0] ini_r, ini_nxt;
    logic       fen_r, fen_nxt;
    logic [2:0] cr3_r, cr3_nxt;
    logic       rel, rel_ok;

    // shadow of the config bits, rebuilt from bus writes
    always_comb
    begin
        ini_nxt = ini_r;
        fen_nxt = fen_r;
        cr3_nxt = cr3_r;
        if (lp_mode)
        begin
            ini_nxt = 2'h0;
            fen_nxt = 1'b0;
            cr3_nxt = 3'h0;
        end
        else if (clk_en && reg_wr)
        begin
            if (reg_addr == OFS_CR1) ini_nxt = reg_wdata[1:0];
            if (reg_addr == OFS_CR2) fen_nxt = reg_wdata[CR2_FEN_BIT];
            if (reg_addr == OFS_CR3) cr3_nxt = reg_wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn) {ini_r, fen_r, cr3_r} <= '0;
        else       {ini_r, fen_r, cr3_r} <= {ini_nxt, fen_nxt, cr3_nxt};
    end

    assign rel    = clk_en && reg_wr && !lp_mode && reg_addr == OFS_CR2
                    && reg_wdata[CR2_REL_BIT];
    assign rel_ok = rel && cr3_r == 3'h0;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_irq_one_cycle: assert property (
        fault_stop_irq |=> !fault_stop_irq)
        else $error("stop request longer than one cycle");
    a_flag_rise_irq: assert property (
        $rose(fault_stop_flag) |-> fault_stop_irq)
        else $error("stop flag rose without request");
    a_irq_with_flag: assert property (
        fault_stop_irq |-> fault_stop_flag)
        else $error("stop request while flag low");
    a_stop_cause: assert property (
        $rose(fault_stop_flag) |-> $past(fen_r)
        && !$past(fault_stop_pin_n, 2) && !$past(fault_stop_pin_n, 3)
        && !$past(fault_stop_pin_n, 4) && !$past(fault_stop_pin_n, 5))
        else $error("stop without long low");
    a_stop_delay: assert property (
        (fen_r && !fault_stop_pin_n)[*4] |-> ##[1:2] fault_stop_flag)
        else $error("stop too late");
    a_outs_forced: assert property (
        fault_stop_flag && $past(fault_stop_flag)
        |-> ppg1_out == $past(ini_r[0]) && ppg2_out == $past(ini_r[1]))
        else $error("outputs not at idle level");
    a_release_clears: assert property (
        rel_ok && fault_stop_pin_n && $past(fault_stop_pin_n)
        && $past(fault_stop_pin_n, 2) |=> !fault_stop_flag)
        else $error("release not taken");
    a_release_refused: assert property (
        rel && cr3_r != 3'h0 && fault_stop_flag |=> fault_stop_flag)
        else $error("release taken");
    a_rerelease_irq: assert property (
        (fen_r && !fault_stop_pin_n)[*5] ##0 rel_ok
        |-> ##1 fault_stop_flag ##[0:5] fault_stop_irq)
        else $error("no re-entry on release with pin low");
    a_flag_readback: assert property (
        $past(reg_rd && reg_addr == OFS_CR3)
        |-> reg_rdata[CR3_FLAG_BIT] == $past(fault_stop_flag))
        else $error("flag bit wrong on read");
    a_lowpower_init: assert property (
        $past(reg_rd && reg_addr == OFS_CR3 && lp_mode) && $past(lp_mode, 2)
        |-> reg_rdata[6:0] == 7'h00)
        else $error("timer not initialized in low power");

    c_stop: cover property ($rose(fault_stop_flag));
    c_release: cover property (rel_ok && fault_stop_flag);
    c_lowpower: cover property (lp_mode && reg_rd);
endmodule // pes_emergency_stop_chk

bind pes_emergency_stop pes_emergency_stop_chk pes_emergency_stop_chk_i (
    .ref_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .lp_mode, .fault_stop_pin_n, .ppg1_out, .ppg1_oe,
    .ppg2_out, .ppg2_oe, .fault_stop_flag, .fault_stop_irq);

// [test/pes_fault_src.sv]
// external fault source driving the active-low stop pin
`timescale 1ns/10ps
module pes_fault_src
(
    // clock
    input  wire logic       ref_clk,
    // requests from the bench
    input  wire logic       go,
    input  wire logic [7:0] len,
    input  wire logic       hold,
    // stop pin, pulled up while idle
    output logic            pin_n
);
    logic [7:0] left_r = 8'h00;

    // lows change on the fast clock only, so each spans whole periods
    always @(posedge ref_clk)
        if (go) left_r <= len;
        else if (left_r != 8'h00) left_r <= left_r - 8'h01;

    assign pin_n = !(hold || left_r != 8'h00);
endmodule // pes_fault_src

// [test/pes_emergency_stop_tb.sv]
// self-checking bench for the emergency output-stop block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("wrong value at %0t: %h not %h", $time, g, e); \
    end end
module pes_emergency_stop_tb
    import pes_pkg::*;
;
    logic              ref_clk, rstn, clk_en, reg_wr, reg_rd, lp_mode;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic              fault_stop_pin_n, fault_stop_flag, fault_stop_irq;
    logic              ppg1_out, ppg1_oe, ppg2_out, ppg2_oe, go, hold;
    logic [7:0]        flt_len, m_per, m_dead;
    logic [2:0]        m_cr2, m_cr3;
    logic [1:0]        m_ini;
    logic              m_flag, m_run;
    int                n_errors, samples_checked, n_irq, exp_irq;
    integer            seed = 32'h03b73da4;

    pes_emergency_stop pes_emergency_stop_i (.ref_clk, .rstn, .clk_en,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lp_mode,
        .fault_stop_pin_n, .ppg1_out, .ppg1_oe, .ppg2_out, .ppg2_oe,
        .fault_stop_flag, .fault_stop_irq);
    pes_fault_src pes_fault_src_i (.ref_clk, .go, .len(flt_len), .hold,
        .pin_n(fault_stop_pin_n));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
        if (fault_stop_irq === 1'b1) n_irq++;

    task finish_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task mreset;
        {m_ini, m_cr2, m_cr3, m_run} = '0;
        m_per  = RST_PERIOD;
        m_dead = RST_DEAD;
    endtask

    // bus write plus the reference model of the registers
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (!lp_mode)
            case (a)
                3'h0: m_ini = d[1:0];
                3'h1:
                begin
                    // a release with the pin still low re-arms at once
                    if (d[7] && m_cr3 == 3'h0) m_flag = hold && d[2];
                    if (d[7] && m_cr3 == 3'h0 && m_flag) exp_irq++;
                    m_cr2 = d[2:0];
                end
                3'h2:
                begin
                    m_run = d[0] ? (m_run || !m_flag) : 1'b0;
                    m_cr3 = d[2:0];
                end
                3'h3: m_per = d;
                3'h4: m_dead = d;
                default: ;
            endcase
    endtask

    task rd_chk(input logic [2:0] a);
        logic [7:0] e;
        case (a)
            3'h0: e = {6'h00, m_ini};
            3'h1: e = {5'h00, m_cr2};
            3'h2: e = {m_flag, m_run, 3'h0, m_cr3};
            3'h3: e = m_per;
            3'h4: e = m_dead;
            default: e = 8'h00;
        endcase
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask

    task fault(input logic [7:0] n);
        @(posedge ref_clk);
        go <= 1'b1; flt_len <= n;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask

    task expect_stop;
        int c;
        c = 0;
        while (fault_stop_flag !== 1'b1 && c < 60)
        begin
            @(posedge ref_clk);
            #1 c++;
        end
        `CHK(c <= 40, 1'b1)
        m_flag = 1'b1;
        exp_irq++;
        repeat (2) @(posedge ref_clk);
        #1 `CHK({ppg2_out, ppg1_out}, m_ini)
        `CHK({ppg2_oe, ppg1_oe}, m_cr2[1:0])
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        finish_test;
    end

    initial
    begin
        {rstn, reg_wr, reg_rd, lp_mode, go, hold, m_flag} = '0;
        {reg_addr, reg_wdata, flt_len, n_irq, exp_irq} = '0;
        clk_en = 1'b1;
        mreset;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++) rd_chk(a[2:0]);
        wr(3'h3, 8'($random(seed)));
        wr(3'h4, 8'($random(seed)));
        rd_chk(3'h3);
        rd_chk(3'h4);
        wr(3'h1, 8'h03);
        fault(8'd10);
        repeat (15) @(posedge ref_clk);
        #1 `CHK(fault_stop_flag, 1'b0)
        // armed from here until low-power mode, but three lows are below the four-low filter, so no stop
        wr(3'h1, 8'h07);
        fault(8'd3);
        repeat (15) @(posedge ref_clk);
        #1 `CHK(fault_stop_flag, 1'b0)
        for (int i = 0; i < 4; i++)
        begin
            wr(3'h0, i[7:0]);
            wr(3'h1, 8'h04 | i[7:0]);
            if (i[0]) wr(3'h2, 8'h01);
            fault(8'(4 + {$random(seed)} % 4));
            expect_stop;
            rd_chk(3'h2);
            wr(3'h2, 8'h00);
            for (int j = 0; j < 3; j++)
            begin
                wr(3'h2, 8'h01 << j);
                wr(3'h1, 8'h87);
                rd_chk(3'h2);
            end
            wr(3'h2, 8'h00);
            wr(3'h1, 8'h87);
            rd_chk(3'h2);
            `CHK(n_irq, exp_irq)
        end
        @(posedge ref_clk) hold <= 1'b1;
        expect_stop;
        wr(3'h2, 8'h00);
        wr(3'h1, 8'h87);
        repeat (8) @(posedge ref_clk);
        rd_chk(3'h2);
        `CHK(n_irq, exp_irq)
        @(posedge ref_clk) hold <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wr(3'h1, 8'h87);
        rd_chk(3'h2);
        wr(3'h0, 8'h03);
        wr(3'h2, 8'h01);
        rd_chk(3'h2);
        @(posedge ref_clk) lp_mode <= 1'b1;
        mreset;
        repeat (3) @(posedge ref_clk);
        rd_chk(3'h2);
        wr(3'h3, 8'h12);
        rd_chk(3'h0);
        @(posedge ref_clk) lp_mode <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd_chk(3'h3);
        wr(3'h3, 8'h12);
        rd_chk(3'h3);
        wr(3'h2, 8'h00);
        @(posedge ref_clk) lp_mode <= 1'b1;
        mreset;
        repeat (3) @(posedge ref_clk);
        rd_chk(3'h3);
        finish_test;
    end
endmodule // pes_emergency_stop_tb
